// ==== include/adcsq_pkg.sv ====
// Purpose : Shared constants for the converter sequencer control block
// Assumes : 8-bit special-function register port, 100 MHz system clock
// Notes   : Offsets are special-function register addresses
package adcsq_pkg;
  // ==========================================================
  // Register addresses
  localparam logic [7:0] ADDR_PRIMARY_CONTROL = 8'hE2;
  localparam logic [7:0] ADDR_FORMAT_RATE     = 8'hE3;
  localparam logic [7:0] ADDR_RESULT_LOW      = 8'hE4;
  localparam logic [7:0] ADDR_RESULT_HIGH     = 8'hE5;
  localparam logic [7:0] ADDR_LOWER_LIMIT     = 8'hE6;
  localparam logic [7:0] ADDR_UPPER_LIMIT     = 8'hE7;
  // ==========================================================
  // Reset values
  localparam logic [7:0] RST_PRIMARY_CONTROL  = 8'h00;
  localparam logic [7:0] RST_FORMAT_RATE      = 8'h00;
  localparam logic [7:0] RST_LOWER_LIMIT      = 8'h00;
  localparam logic [7:0] RST_UPPER_LIMIT      = 8'h00;
  // ==========================================================
  // Primary control fields
  localparam int BIT_HIGH_CLEAR   = 7;
  localparam int BIT_HIGH_STATUS  = 6;
  localparam int BIT_LOW_CLEAR    = 5;
  localparam int BIT_LOW_STATUS   = 4;
  localparam int BIT_INVERTED     = 3;
  localparam int BIT_REF_CONTROL  = 2;
  localparam int BIT_CONTINUOUS   = 1;
  localparam int BIT_START_STATUS = 0;
  // Format, rate and power fields
  localparam int BIT_JUSTIFY      = 7;
  localparam int RATE_MSB         = 6;
  localparam int RATE_LSB         = 4;
  localparam int BIT_HOLD_A_EN    = 3;
  localparam int BIT_HOLD_B_EN    = 2;
  localparam int BIT_AUTO_SAVE    = 1;
  localparam int BIT_INPUT_SEL    = 0;
  // ==========================================================
  // Timing
  localparam int CONV_CYCLES      = 156;
  localparam int DIV_SLOWEST      = 8832;
  localparam int DIV_SLOW         = 4416;
  localparam int DIV_MID          = 2208;
  localparam int DIV_FAST         = 1104;
  localparam int DIV_FASTEST      = 552;
  localparam int CLK_MHZ          = 100;
  // Auto power-save wakes the track/holds this long before a start
  localparam int WAKE_NS          = 2000;
  localparam int WAKE_CYCLES      = (WAKE_NS * CLK_MHZ + 999) / 1000;
  localparam int RESULT_BITS      = 10;
endpackage

// ==== logic/adcsq_rate_div.sv ====
// Purpose : Continuous-mode start pulse divider
// Assumes : Restart held high while continuous mode is off
// Notes   : Also flags the wake window ahead of each pulse
`timescale 1ns/1ps
module adcsq_rate_div #(
  parameter int CNT_W = 14
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             restart_i,
  input  wire logic [2:0]       rate_i,
  input  wire logic [CNT_W-1:0] wake_i,
  output logic                  tick_o,
  output logic                  wake_o
);
  import adcsq_pkg::*;
  logic [CNT_W-1:0] count_r;
  logic [CNT_W-1:0] div_nxt;

  initial begin
    if (CNT_W < 14) $error("divider counter too narrow");
  end

  // ==========================================================
  // Divisor select
  always_comb begin
    case (rate_i)
      3'h1:    div_nxt = CNT_W'(DIV_SLOWEST);
      3'h3:    div_nxt = CNT_W'(DIV_SLOW);
      3'h5:    div_nxt = CNT_W'(DIV_MID);
      3'h7:    div_nxt = CNT_W'(DIV_FAST);
      default: div_nxt = CNT_W'(DIV_FASTEST);
    endcase
  end

  // ==========================================================
  // Counter, restarts when continuous mode turns on
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_r <= '0;
    end else if (restart_i || count_r + 1'b1 >= div_nxt) begin
      count_r <= '0;
    end else begin
      count_r <= count_r + 1'b1;
    end
  end

  assign tick_o = !restart_i && (count_r + 1'b1 >= div_nxt);
  assign wake_o = (div_nxt - count_r) <= wake_i;
endmodule

// ==== logic/adcsq_conv_core.sv ====
// Purpose : Converter core sequencer model
// Assumes : Input sampled once at start
// Notes   : Result stands for the full conversion time
`timescale 1ns/1ps
module adcsq_conv_core (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic       start_i,
  input  wire logic [9:0] sample_i,
  output logic            busy_o,
  output logic            done_o,
  output logic [9:0]      result_o
);
  import adcsq_pkg::*;
  logic [7:0] count_r;
  logic [9:0] held_r;

  // ==========================================================
  // Sequencer: capture at start, finish after the conversion time
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count_r <= 8'h00;
      busy_o  <= 1'b0;
      done_o  <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o  <= 1'b1;
        count_r <= 8'(CONV_CYCLES - 1);
      end else if (busy_o) begin
        if (count_r == 8'h00) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end else begin
          count_r <= count_r - 8'h01;
        end
      end
    end
  end

  // Data path has no reset; nothing consumes it before done
  always_ff @(posedge clk_i) begin
    if (start_i && !busy_o) begin
      held_r <= sample_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (busy_o && count_r == 8'h00) begin
      result_o <= held_r;
    end
  end
endmodule

// ==== logic/adcsq_top.sv ====
// Purpose : Control around a 10-bit converter on the special-function bus
// Assumes : Single 100 MHz clock, active-low asynchronous reset
// Notes   : Analogue front end is reduced to two digital sample buses
// Operation
// - Writing one to start bit begins a conversion; zero does nothing
// - A conversion finishes within 156 system clock cycles
// - Start/status bit reads one while converting, zero afterwards
// - Result bytes are invalid while a conversion runs
// - Status also follows each automatic continuous conversion
// - Justify bit zero selects left, one selects right
// - Unused result bits read zero; layout follows justify setting
// - Rate codes divide clock by 8832/4416/2208/1104, else 552
// - Bit 3 enables track/hold A, clear powers it down and bypasses
// - Bit 2 enables track/hold B, clear powers it down and bypasses
// - Enabled track/hold holds during conversion, tracks otherwise
// - Explicit power-save overrides auto power-save
// - Auto power-save powers both track/holds down between conversions, in continuous mode only
// - Input select one picks second input, zero picks first
// - Reset leaves result bytes untouched
// - Each conversion end compares bits 9-2 with both limits
// - Normal mode flags above/below; inverted mode flags inside range
// - Status flags read-only; writing clear bit clears, reads zero
// - Continuous enable starts conversions at the selected rate
// - Either flag drives the active-low interrupt line
`timescale 1ns/1ps
module adcsq_top (
  input  wire logic       clk_i,
  input  wire logic       resetn_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  output logic            sfr_hit_o,
  input  wire logic [9:0] analog_input_first_i,
  input  wire logic [9:0] analog_input_second_i,
  output logic            hold_a_power_o,
  output logic            hold_b_power_o,
  output logic            hold_a_hold_o,
  output logic            hold_b_hold_o,
  output logic            ref_internal_o,
  output logic            threshold_irq_line_n_o
);
  import adcsq_pkg::*;

  // ==========================================================
  // Registers and internal signals
  logic [7:0] primary_r;
  logic [7:0] format_r;
  logic [7:0] lower_limit_r;
  logic [7:0] upper_limit_r;
  logic [7:0] result_low_r;
  logic [7:0] result_high_r;
  logic       high_flag_r;
  logic       low_flag_r;
  logic       pending_r;
  logic       busy;
  logic       done;
  logic [9:0] result;
  logic [9:0] sample;
  logic       tick;
  logic       wake;
  logic       start;
  logic       wr_primary;
  logic       man_start;
  logic       continuous;
  logic       auto_save;
  logic       set_high;
  logic       set_low;
  logic [7:0] top8;

  assign wr_primary = sfr_wr_i && sfr_addr_i == ADDR_PRIMARY_CONTROL;
  assign man_start  = wr_primary && sfr_wdata_i[BIT_START_STATUS];
  assign continuous = primary_r[BIT_CONTINUOUS];
  assign auto_save  = format_r[BIT_AUTO_SAVE] && continuous;

  // Both start sources merge; a start while busy is dropped by the core
  assign start = man_start || (continuous && tick);

  // ==========================================================
  // Control registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      primary_r <= RST_PRIMARY_CONTROL;
    end else if (wr_primary) begin
      primary_r <= sfr_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      format_r      <= RST_FORMAT_RATE;
      lower_limit_r <= RST_LOWER_LIMIT;
      upper_limit_r <= RST_UPPER_LIMIT;
    end else if (sfr_wr_i) begin
      case (sfr_addr_i)
        ADDR_FORMAT_RATE: format_r      <= sfr_wdata_i;
        ADDR_LOWER_LIMIT: lower_limit_r <= sfr_wdata_i;
        ADDR_UPPER_LIMIT: upper_limit_r <= sfr_wdata_i;
        default: ;
      endcase
    end
  end

  // Status shows one from the start write edge until the result bytes load
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pending_r <= 1'b0;
    end else begin
      pending_r <= start && !busy;
    end
  end

  // ==========================================================
  // Input select and converter
  assign sample = format_r[BIT_INPUT_SEL] ? analog_input_second_i
                                          : analog_input_first_i;

  adcsq_rate_div #(
    .CNT_W (14)
  ) u_div (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .restart_i (!continuous),
    .rate_i    (format_r[RATE_MSB:RATE_LSB]),
    .wake_i    (14'(WAKE_CYCLES)),
    .tick_o    (tick),
    .wake_o    (wake)
  );

  adcsq_conv_core u_core (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .start_i  (start),
    .sample_i (sample),
    .busy_o   (busy),
    .done_o   (done),
    .result_o (result)
  );

  // ==========================================================
  // Result bytes, no reset so contents stay unknown until first done
  always_ff @(posedge clk_i) begin
    if (done) begin
      if (format_r[BIT_JUSTIFY]) begin
        result_low_r  <= result[7:0];
        result_high_r <= {6'h00, result[9:8]};
      end else begin
        result_low_r  <= {result[1:0], 6'h00};
        result_high_r <= result[9:2];
      end
    end
  end

  // ==========================================================
  // Threshold compare on every conversion end
  assign top8 = result[9:2];
  always_comb begin
    if (primary_r[BIT_INVERTED]) begin
      set_high = top8 <= upper_limit_r && top8 >= lower_limit_r;
      set_low  = set_high;
    end else begin
      set_high = top8 > upper_limit_r;
      set_low  = top8 < lower_limit_r;
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      high_flag_r <= 1'b0;
      low_flag_r  <= 1'b0;
    end else begin
      if (done && set_high) begin
        high_flag_r <= 1'b1;
      end else if (wr_primary && sfr_wdata_i[BIT_HIGH_CLEAR]) begin
        high_flag_r <= 1'b0;
      end
      if (done && set_low) begin
        low_flag_r <= 1'b1;
      end else if (wr_primary && sfr_wdata_i[BIT_LOW_CLEAR]) begin
        low_flag_r <= 1'b0;
      end
    end
  end

  assign threshold_irq_line_n_o = !(high_flag_r || low_flag_r);

  // ==========================================================
  // Track/hold power: explicit disable beats auto power-save
  assign hold_a_power_o = format_r[BIT_HOLD_A_EN] &&
                          (!auto_save || busy || wake);
  assign hold_b_power_o = format_r[BIT_HOLD_B_EN] &&
                          (!auto_save || busy || wake);
  assign hold_a_hold_o  = format_r[BIT_HOLD_A_EN] && busy;
  assign hold_b_hold_o  = format_r[BIT_HOLD_B_EN] && busy;
  assign ref_internal_o = primary_r[BIT_REF_CONTROL];

  // ==========================================================
  // Read port
  always_comb begin
    sfr_hit_o   = 1'b1;
    sfr_rdata_o = 8'h00;
    case (sfr_addr_i)
      ADDR_PRIMARY_CONTROL: begin
        sfr_rdata_o = {1'b0, high_flag_r, 1'b0, low_flag_r,
                       primary_r[3:1], busy || pending_r || done};
      end
      ADDR_FORMAT_RATE: sfr_rdata_o = format_r;
      ADDR_RESULT_LOW:  sfr_rdata_o = result_low_r;
      ADDR_RESULT_HIGH: sfr_rdata_o = result_high_r;
      ADDR_LOWER_LIMIT: sfr_rdata_o = lower_limit_r;
      ADDR_UPPER_LIMIT: sfr_rdata_o = upper_limit_r;
      default:          sfr_hit_o   = 1'b0;
    endcase
  end

  // ==========================================================
  // Checks
  status_on_start_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    man_start && !busy |=> busy)
    else $error("manual start did not begin conversion");
  conv_length_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(busy) |-> ##[1:156] done)
    else $error("conversion too long");
  status_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    busy |-> (sfr_addr_i != ADDR_PRIMARY_CONTROL || sfr_rdata_o[0]))
    else $error("status reads zero while busy");
  right_just_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    done && format_r[7] |=> result_high_r[7:2] == 6'h00)
    else $error("right justified upper bits not zero");
  left_just_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    done && !format_r[7] |=> result_high_r == $past(result[9:2]))
    else $error("left justified byte wrong");
  hold_off_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !format_r[3] |-> !hold_a_power_o && !hold_a_hold_o)
    else $error("disabled track/hold A active");
  hold_during_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    format_r[2] && busy |-> hold_b_hold_o && hold_b_power_o)
    else $error("track/hold B not holding");
  flag_set_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    done && set_high |=> high_flag_r ##0 !threshold_irq_line_n_o)
    else $error("high flag or irq missing");
  clear_read_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    sfr_addr_i == ADDR_PRIMARY_CONTROL |-> !sfr_rdata_o[7] && !sfr_rdata_o[5])
    else $error("clear bits read nonzero");
  auto_start_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
    continuous && tick && !busy |=> busy)
    else $error("continuous start missed");
  manual_cov: cover property (@(posedge clk_i) man_start ##1 busy);
  cont_cov:   cover property (@(posedge clk_i) continuous && tick);
  flag_cov:   cover property (@(posedge clk_i) done && set_low);
endmodule

// ==== testbench/adcsq_input_model.sv ====
// Purpose : Two analogue inputs seen as digital sample buses
// Assumes : Levels come from the bench, hold flags from the block
// Notes   : Inputs keep moving while held, so only the start sample counts
`timescale 1ns/1ps
module adcsq_input_model (
  input  wire logic [9:0] level_first_i,
  input  wire logic [9:0] level_second_i,
  input  wire logic       hold_a_i,
  input  wire logic       hold_b_i,
  output logic      [9:0] sample_first_o,
  output logic      [9:0] sample_second_o
);
  // ==========================================================
  // Sources
  // Inverted while held: a core that samples late reads garbage
  assign sample_first_o  = hold_a_i ? ~level_first_i : level_first_i;
  assign sample_second_o = hold_b_i ? ~level_second_i : level_second_i;
endmodule

// ==== testbench/testbench.sv ====
// Purpose : Self-checking bench for the converter sequencer control
// Assumes : Inputs change on the falling clock edge
// Notes   : Continuous rates run at their full divisor length
`timescale 1ns/1ps
module testbench;
  import adcsq_pkg::*;
  // ==========================================================
  // Signals
  logic       clk_i;
  logic       resetn_i;
  logic [7:0] sfr_addr_i;
  logic       sfr_wr_i;
  logic [7:0] sfr_wdata_i;
  logic [7:0] sfr_rdata_o;
  logic       sfr_hit_o;
  logic [9:0] smp_first;
  logic [9:0] smp_second;
  logic [9:0] lvl_first;
  logic [9:0] lvl_second;
  logic       pwr_a;
  logic       pwr_b;
  logic       hold_a;
  logic       hold_b;
  logic       irq_n;
  logic       ref_int;
  int         bad_count;
  int         comparisons;
  // ==========================================================
  // Instances
  adcsq_top adcsq_top_inst (
    .clk_i                  (clk_i),
    .resetn_i               (resetn_i),
    .sfr_addr_i             (sfr_addr_i),
    .sfr_wr_i               (sfr_wr_i),
    .sfr_rd_i               (1'b0),
    .sfr_wdata_i            (sfr_wdata_i),
    .sfr_rdata_o            (sfr_rdata_o),
    .sfr_hit_o              (sfr_hit_o),
    .analog_input_first_i   (smp_first),
    .analog_input_second_i  (smp_second),
    .hold_a_power_o         (pwr_a),
    .hold_b_power_o         (pwr_b),
    .hold_a_hold_o          (hold_a),
    .hold_b_hold_o          (hold_b),
    .ref_internal_o         (ref_int),
    .threshold_irq_line_n_o (irq_n)
  );
  adcsq_input_model adcsq_input_model_inst (
    .level_first_i   (lvl_first),
    .level_second_i  (lvl_second),
    .hold_a_i        (hold_a),
    .hold_b_i        (hold_b),
    .sample_first_o  (smp_first),
    .sample_second_o (smp_second)
  );
  // ==========================================================
  // Helpers
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_cnt(input string n, input int e, input int g);
    comparisons++;
    if (g != e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i  = a;
    sfr_wdata_i = d;
    sfr_wr_i    = 1'b1;
    @(negedge clk_i);
    sfr_wr_i    = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr_i = a;
    #1;
    d = sfr_rdata_o;
  endtask
  // Waits for the status bit to move into level b
  task automatic wait_status(input logic b, output int n);
    logic [7:0] v;
    logic       prev;
    n = 0;
    v = {8{b}};
    do begin
      prev = v[0];
      @(negedge clk_i);
      n++;
      rd(ADDR_PRIMARY_CONTROL, v);
    end while (!(prev === ~b && v[0] === b) && n < 10000);
  endtask
  task automatic convert(input logic [7:0] ctl, input logic [1:0] hmask);
    int         n;
    logic [7:0] v;
    wr(ADDR_PRIMARY_CONTROL, ctl | 8'h01);
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
      rd(ADDR_PRIMARY_CONTROL, v);
      if (n == 1) begin
        chk("status busy", 8'h01, v & 8'h01);
        chk("hold busy", hmask, {hold_a, hold_b} & hmask);
      end
    end while (v[0] !== 1'b0 && n < 400);
    chk_cnt("conversion cycles", 157, n);
    chk("hold after", 8'h00, {hold_a, hold_b} & hmask);
  endtask
  task automatic results(input logic [7:0] lo, input logic [7:0] hi,
                         input logic [7:0] st);
    logic [7:0] v;
    rd(ADDR_RESULT_LOW, v);
    chk("result low", lo, v);
    rd(ADDR_RESULT_HIGH, v);
    chk("result high", hi, v);
    rd(ADDR_PRIMARY_CONTROL, v);
    chk("flags", st, v);
    chk("irq line", {7'h00, !(st[6] || st[4])}, {7'h00, irq_n});
  endtask
  // ==========================================================
  // Scenarios
  task automatic test_reset();
    logic [7:0] v;
    logic [7:0] adr [4] = '{ADDR_PRIMARY_CONTROL, ADDR_FORMAT_RATE,
                            ADDR_LOWER_LIMIT, ADDR_UPPER_LIMIT};
    foreach (adr[i]) begin
      rd(adr[i], v);
      chk("reset value", 8'h00, v);
    end
    chk("hit mapped", 8'h01, sfr_hit_o);
    rd(8'h10, v);
    chk("hit unmapped", 8'h00, sfr_hit_o);
    chk("reset outputs", 8'h01, {pwr_a, pwr_b, hold_a, hold_b, irq_n});
  endtask
  task automatic test_right();
    logic [7:0] v;
    wr(ADDR_LOWER_LIMIT, 8'h40);
    wr(ADDR_UPPER_LIMIT, 8'h80);
    wr(ADDR_FORMAT_RATE, 8'h85);
    lvl_second = 10'h2A5;
    chk("power b only", 8'h01, {pwr_a, pwr_b});
    repeat (2500) @(negedge clk_i);
    convert(8'h00, 2'b01);
    results(8'hA5, 8'h02, 8'h40);
    wr(ADDR_PRIMARY_CONTROL, 8'h80);
    rd(ADDR_PRIMARY_CONTROL, v);
    chk("high clear", 8'h00, v);
    wr(ADDR_PRIMARY_CONTROL, 8'h00);
    repeat (3) @(negedge clk_i);
    rd(ADDR_PRIMARY_CONTROL, v);
    chk("zero start", 8'h00, v);
    wr(ADDR_PRIMARY_CONTROL, 8'h04);
    chk("ref control", 8'h01, {7'h00, ref_int});
    wr(ADDR_PRIMARY_CONTROL, 8'h00);
    chk("ref control off", 8'h00, {7'h00, ref_int});
    wr(ADDR_RESULT_LOW, 8'h5A);
    rd(ADDR_RESULT_LOW, v);
    chk("result read only", 8'hA5, v);
  endtask
  task automatic test_left();
    logic [7:0] v;
    wr(ADDR_FORMAT_RATE, 8'h00);
    lvl_first = 10'h0C3;
    chk("power none", 8'h00, {pwr_a, pwr_b});
    convert(8'h00, 2'b00);
    results(8'hC0, 8'h30, 8'h10);
    wr(ADDR_PRIMARY_CONTROL, 8'h20);
    rd(ADDR_PRIMARY_CONTROL, v);
    chk("low clear", 8'h00, v);
    lvl_first = 10'h180;
    convert(8'h08, 2'b00);
    results(8'h00, 8'h60, 8'h58);
    wr(ADDR_PRIMARY_CONTROL, 8'hA8);
    rd(ADDR_PRIMARY_CONTROL, v);
    chk("both clear", 8'h08, v);
    wr(ADDR_PRIMARY_CONTROL, 8'h00);
  endtask
  task automatic test_rates();
    int         n;
    logic [2:0] code [6] = '{3'h1, 3'h3, 3'h5, 3'h7, 3'h0, 3'h6};
    int         div  [6] = '{DIV_SLOWEST, DIV_SLOW, DIV_MID, DIV_FAST,
                             DIV_FASTEST, DIV_FASTEST};
    foreach (code[i]) begin
      wr(ADDR_FORMAT_RATE, {1'b0, code[i], 4'h0});
      wr(ADDR_PRIMARY_CONTROL, 8'h02);
      wait_status(1'b1, n);
      wait_status(1'b1, n);
      chk_cnt("rate period", div[i], n);
      wr(ADDR_PRIMARY_CONTROL, 8'h00);
      repeat (200) @(negedge clk_i);
    end
  endtask
  task automatic test_auto_save();
    int n;
    wr(ADDR_FORMAT_RATE, 8'h0A);
    wr(ADDR_PRIMARY_CONTROL, 8'h02);
    wait_status(1'b1, n);
    chk("power at start", 8'h02, {pwr_a, pwr_b});
    chk("hold at start", 8'h01, hold_a);
    wait_status(1'b0, n);
    repeat (10) @(negedge clk_i);
    chk("power between", 8'h00, {pwr_a, pwr_b, hold_a});
    wait_status(1'b1, n);
    chk("power again", 8'h02, {pwr_a, pwr_b});
    wr(ADDR_PRIMARY_CONTROL, 8'h00);
    repeat (200) @(negedge clk_i);
  endtask
  // ==========================================================
  // Run control
  task automatic end_of_test();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Whole run is near 40000 cycles; twice that means a hang
  initial begin
    #800000;
    bad_count++;
    end_of_test();
  end
  initial begin
    bad_count   = 0;
    comparisons = 0;
    resetn_i    = 1'b0;
    sfr_addr_i  = 8'hE2;
    sfr_wr_i    = 1'b0;
    sfr_wdata_i = 8'h00;
    lvl_first   = 10'h3FF;
    lvl_second  = 10'h155;
    repeat (16) @(negedge clk_i);
    resetn_i = 1'b1;
    test_reset();
    test_right();
    test_left();
    test_rates();
    test_auto_save();
    end_of_test();
  end
endmodule
